// ==== inc/bsf_pkg.sv ====
/*
 * Package for the bit, shift and flag unit: register offsets, field
 * positions, reset values, cycle counts, opcodes and the command carrier.
 * Assumes a 32-bit APB master and one core clock.
 */
package bsf_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CMD     = 8'h00;
	localparam logic [7:0] OFS_OPERAND = 8'h04;
	localparam logic [7:0] OFS_RESULT  = 8'h08;
	localparam logic [7:0] OFS_FLAGS   = 8'h0C;
	localparam logic [7:0] OFS_STATUS  = 8'h10;
	localparam logic [7:0] OFS_IO_SEL  = 8'h14;
	localparam logic [7:0] OFS_IO_DATA = 8'h18;

	// Command word field positions
	localparam int CMD_OP_LSB  = 0;
	localparam int CMD_BIT_LSB = 8;
	localparam int CMD_IO_LSB  = 16;
	localparam int CMD_NVM_POS = 24;

	// Status word field positions
	localparam int STAT_BUSY_POS   = 0;
	localparam int STAT_NVM_POS    = 1;
	localparam int STAT_CYCLES_LSB = 8;

	// Flag positions inside status_register
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// Reset values
	localparam logic [7:0]  FLAGS_RESET   = 8'h00;
	localparam logic [7:0]  OPERAND_RESET = 8'h00;
	localparam logic [31:0] CMD_RESET     = 32'h0000_0000;

	// Cycle counts
	localparam logic [7:0] CYC_ONE       = 8'h01;
	localparam logic [7:0] CYC_TWO       = 8'h02;
	localparam logic [7:0] CYC_LOW_IO    = 8'h01;
	localparam logic [7:0] CYC_NVM_MIN   = 8'h01;
	localparam logic [6:0] LOW_IO_LIMIT  = 7'h40;

	typedef enum logic [4:0] {
		OP_NOP       = 5'h00, OP_SHIFT_L  = 5'h01, OP_SHIFT_R = 5'h02,
		OP_ROT_L     = 5'h03, OP_ROT_R    = 5'h04, OP_SHIFT_A = 5'h05,
		OP_SWAP      = 5'h06, OP_IO_SET   = 5'h07, OP_IO_CLR  = 5'h08,
		OP_BIT_TO_T  = 5'h09, OP_T_TO_BIT = 5'h0A, OP_SR_SET  = 5'h0B,
		OP_SR_CLR    = 5'h0C, OP_SET_C    = 5'h0D, OP_CLR_C   = 5'h0E,
		OP_SET_N     = 5'h0F, OP_CLR_N    = 5'h10, OP_SET_Z   = 5'h11,
		OP_CLR_Z     = 5'h12, OP_SET_S    = 5'h13, OP_CLR_S   = 5'h14,
		OP_SET_V     = 5'h15, OP_CLR_V    = 5'h16, OP_SET_T   = 5'h17,
		OP_CLR_T     = 5'h18, OP_SET_H    = 5'h19, OP_CLR_H   = 5'h1A,
		OP_IRQ_ON    = 5'h1B, OP_IRQ_OFF  = 5'h1C, OP_BREAK   = 5'h1D,
		OP_SLEEP     = 5'h1E, OP_WDOG     = 5'h1F
	} op_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_EXEC = 1'b1
	} state_t;

	typedef struct packed {
		logic       nvm;
		logic [6:0] io_addr;
		logic [2:0] bit_sel;
		op_t        op;
	} cmd_t;

endpackage

// ==== hdl/bit_shift_flag_unit.sv ====
/*
 * Bit, shift, rotate and status-flag execution unit with processor
 * control strobes, reached over APB. Holds its own I/O byte space.
 * Assumes an APB master on CLOCK_IN and an NVM busy level from a pin.
 */
module bit_shift_flag_unit #(
	parameter int IO_DEPTH = 128
) (
	// Clock and reset
	input  wire logic        CLOCK_IN,
	input  wire logic        RESETN_IN,
	// APB slave
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [7:0]  PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	// NVM controller state, asynchronous
	input  wire logic        NVM_BUSY_IN,
	// Core control
	output logic             IRQ_ENABLE_OUT,
	output logic             BUSY_OUT,
	output logic             BREAK_OUT,
	output logic             SLEEP_OUT,
	output logic             WDOG_RESTART_OUT
);

	bsf_pkg::state_t state_q;
	bsf_pkg::cmd_t   cmd_q;
	logic [7:0]      operand_q;
	logic [7:0]      result_q;
	logic [7:0]      flags_q;
	logic [7:0]      cnt_q;
	logic [7:0]      cycles_q;
	logic [6:0]      io_sel_q;
	logic [7:0]      io_mem [IO_DEPTH];
	logic [2:0]      nvm_sync_q;
	logic            nvm_busy_q;
	logic            wr_acc;
	logic            rd_setup;
	logic            start;
	logic            finish;
	logic            mapped;
	bsf_pkg::cmd_t   cmd_in;
	logic [7:0]      res_d;
	logic [7:0]      flags_d;
	logic            res_we;
	logic [7:0]      base_cyc;
	logic [7:0]      tot_cyc;

	// Flag op decode: {hit, value, index}
	function automatic logic [4:0] flag_op(input bsf_pkg::op_t op);
		unique case (op)
			bsf_pkg::OP_SET_C:   flag_op = {2'b11, 3'(bsf_pkg::FLAG_C)};
			bsf_pkg::OP_CLR_C:   flag_op = {2'b10, 3'(bsf_pkg::FLAG_C)};
			bsf_pkg::OP_SET_N:   flag_op = {2'b11, 3'(bsf_pkg::FLAG_N)};
			bsf_pkg::OP_CLR_N:   flag_op = {2'b10, 3'(bsf_pkg::FLAG_N)};
			bsf_pkg::OP_SET_Z:   flag_op = {2'b11, 3'(bsf_pkg::FLAG_Z)};
			bsf_pkg::OP_CLR_Z:   flag_op = {2'b10, 3'(bsf_pkg::FLAG_Z)};
			bsf_pkg::OP_SET_S:   flag_op = {2'b11, 3'(bsf_pkg::FLAG_S)};
			bsf_pkg::OP_CLR_S:   flag_op = {2'b10, 3'(bsf_pkg::FLAG_S)};
			bsf_pkg::OP_SET_V:   flag_op = {2'b11, 3'(bsf_pkg::FLAG_V)};
			bsf_pkg::OP_CLR_V:   flag_op = {2'b10, 3'(bsf_pkg::FLAG_V)};
			bsf_pkg::OP_SET_T:   flag_op = {2'b11, 3'(bsf_pkg::FLAG_T)};
			bsf_pkg::OP_CLR_T:   flag_op = {2'b10, 3'(bsf_pkg::FLAG_T)};
			bsf_pkg::OP_SET_H:   flag_op = {2'b11, 3'(bsf_pkg::FLAG_H)};
			bsf_pkg::OP_CLR_H:   flag_op = {2'b10, 3'(bsf_pkg::FLAG_H)};
			bsf_pkg::OP_IRQ_ON:  flag_op = {2'b11, 3'(bsf_pkg::FLAG_I)};
			bsf_pkg::OP_IRQ_OFF: flag_op = {2'b10, 3'(bsf_pkg::FLAG_I)};
			default:             flag_op = 5'h00;
		endcase
	endfunction

	// Shift flags: Z, N, V=N^C, carry given
	function automatic logic [7:0] shift_flags(input logic [7:0] sr,
		input logic [7:0] r, input logic c);
		logic [7:0] f;
		f = sr;
		f[bsf_pkg::FLAG_C] = c;
		f[bsf_pkg::FLAG_Z] = (r == 8'h00);
		f[bsf_pkg::FLAG_N] = r[7];
		f[bsf_pkg::FLAG_V] = r[7] ^ c;
		shift_flags = f;
	endfunction

	assign wr_acc   = PSEL_IN & PENABLE_IN & PWRITE_IN;
	assign rd_setup = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
	// Fields lie apart in the word; gather them by position
	assign cmd_in   = '{
		nvm:     PWDATA_IN[bsf_pkg::CMD_NVM_POS],
		io_addr: PWDATA_IN[bsf_pkg::CMD_IO_LSB +: 7],
		bit_sel: PWDATA_IN[bsf_pkg::CMD_BIT_LSB +: 3],
		op:      bsf_pkg::op_t'(PWDATA_IN[bsf_pkg::CMD_OP_LSB +: 5])
	};
	// Commands written while busy are dropped, not queued
	assign start  = wr_acc & (PADDR_IN == bsf_pkg::OFS_CMD)
		& (state_q == bsf_pkg::ST_IDLE) & mapped;
	// NVM path holds the last cycle while the controller is busy
	assign finish = (state_q == bsf_pkg::ST_EXEC) & (cnt_q == 8'h01)
		& ~(cmd_q.nvm & nvm_busy_q);

	always_comb begin
		unique case (PADDR_IN)
			bsf_pkg::OFS_CMD, bsf_pkg::OFS_OPERAND, bsf_pkg::OFS_RESULT,
			bsf_pkg::OFS_FLAGS, bsf_pkg::OFS_STATUS, bsf_pkg::OFS_IO_SEL,
			bsf_pkg::OFS_IO_DATA: mapped = 1'b1;
			default:              mapped = 1'b0;
		endcase
	end

	assign PREADY_OUT     = 1'b1;
	assign PSLVERR_OUT    = PSEL_IN & PENABLE_IN & ~mapped;
	assign IRQ_ENABLE_OUT = flags_q[bsf_pkg::FLAG_I];
	assign BUSY_OUT       = (state_q == bsf_pkg::ST_EXEC);

	// Listed cycles per operation
	always_comb begin
		unique case (cmd_in.op)
			bsf_pkg::OP_IO_SET, bsf_pkg::OP_IO_CLR: base_cyc = bsf_pkg::CYC_TWO;
			default: base_cyc = bsf_pkg::CYC_ONE;
		endcase
		// Penalties summed here so the sequencer holds only registers
		tot_cyc = base_cyc;
		if ((cmd_in.op == bsf_pkg::OP_IO_SET
			|| cmd_in.op == bsf_pkg::OP_IO_CLR)
			&& cmd_in.io_addr < bsf_pkg::LOW_IO_LIMIT) begin
			tot_cyc = tot_cyc + bsf_pkg::CYC_LOW_IO;
		end
		if (cmd_in.nvm) begin
			tot_cyc = tot_cyc + bsf_pkg::CYC_NVM_MIN;
		end
	end

	// Execution datapath, evaluated on the latched command
	always_comb begin
		logic [4:0] fo;
		logic [7:0] r;
		fo      = flag_op(cmd_q.op);
		r       = operand_q;
		res_d   = operand_q;
		flags_d = flags_q;
		res_we  = 1'b0;
		unique case (cmd_q.op)
			bsf_pkg::OP_SHIFT_L: begin
				r       = {operand_q[6:0], 1'b0};
				res_d   = r;
				res_we  = 1'b1;
				flags_d = shift_flags(flags_q, r, operand_q[7]);
				flags_d[bsf_pkg::FLAG_H] = operand_q[3];
			end
			bsf_pkg::OP_SHIFT_R: begin
				r       = {1'b0, operand_q[7:1]};
				res_d   = r;
				res_we  = 1'b1;
				flags_d = shift_flags(flags_q, r, operand_q[0]);
			end
			bsf_pkg::OP_ROT_L: begin
				r       = {operand_q[6:0], flags_q[bsf_pkg::FLAG_C]};
				res_d   = r;
				res_we  = 1'b1;
				flags_d = shift_flags(flags_q, r, operand_q[7]);
				flags_d[bsf_pkg::FLAG_H] = operand_q[3];
			end
			bsf_pkg::OP_ROT_R: begin
				r       = {flags_q[bsf_pkg::FLAG_C], operand_q[7:1]};
				res_d   = r;
				res_we  = 1'b1;
				flags_d = shift_flags(flags_q, r, operand_q[0]);
			end
			bsf_pkg::OP_SHIFT_A: begin
				r       = {operand_q[7], operand_q[7:1]};
				res_d   = r;
				res_we  = 1'b1;
				flags_d = shift_flags(flags_q, r, operand_q[0]);
			end
			bsf_pkg::OP_SWAP: begin
				res_d  = {operand_q[3:0], operand_q[7:4]};
				res_we = 1'b1;
			end
			bsf_pkg::OP_BIT_TO_T: begin
				flags_d[bsf_pkg::FLAG_T] = operand_q[cmd_q.bit_sel];
			end
			bsf_pkg::OP_T_TO_BIT: begin
				res_d[cmd_q.bit_sel] = flags_q[bsf_pkg::FLAG_T];
				res_we = 1'b1;
			end
			bsf_pkg::OP_SR_SET: begin
				flags_d[cmd_q.bit_sel] = 1'b1;
			end
			bsf_pkg::OP_SR_CLR: begin
				flags_d[cmd_q.bit_sel] = 1'b0;
			end
			bsf_pkg::OP_SET_C, bsf_pkg::OP_CLR_C, bsf_pkg::OP_SET_N,
			bsf_pkg::OP_CLR_N, bsf_pkg::OP_SET_Z, bsf_pkg::OP_CLR_Z,
			bsf_pkg::OP_SET_S, bsf_pkg::OP_CLR_S, bsf_pkg::OP_SET_V,
			bsf_pkg::OP_CLR_V, bsf_pkg::OP_SET_T, bsf_pkg::OP_CLR_T,
			bsf_pkg::OP_SET_H, bsf_pkg::OP_CLR_H, bsf_pkg::OP_IRQ_ON,
			bsf_pkg::OP_IRQ_OFF: begin
				flags_d[fo[2:0]] = fo[3];
			end
			bsf_pkg::OP_NOP, bsf_pkg::OP_IO_SET, bsf_pkg::OP_IO_CLR,
			bsf_pkg::OP_BREAK, bsf_pkg::OP_SLEEP, bsf_pkg::OP_WDOG: begin
				res_we = 1'b0;
			end
		endcase
	end

	// NVM busy pin: three stages, change taken when last two agree
	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			nvm_sync_q <= 3'h0;
			nvm_busy_q <= 1'b0;
		end else begin
			nvm_sync_q <= {nvm_sync_q[1:0], NVM_BUSY_IN};
			if (nvm_sync_q[1] == nvm_sync_q[2]) begin
				nvm_busy_q <= nvm_sync_q[2];
			end
		end
	end

	// Sequencer and cycle counter
	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			state_q  <= bsf_pkg::ST_IDLE;
			cmd_q    <= bsf_pkg::cmd_t'(bsf_pkg::CMD_RESET[15:0]);
			cnt_q    <= 8'h00;
			cycles_q <= 8'h00;
		end else begin
			unique case (state_q)
				bsf_pkg::ST_IDLE: begin
					if (start) begin
						state_q  <= bsf_pkg::ST_EXEC;
						cmd_q    <= cmd_in;
						cnt_q    <= tot_cyc;
						cycles_q <= tot_cyc;
					end
				end
				bsf_pkg::ST_EXEC: begin
					if (finish) begin
						state_q <= bsf_pkg::ST_IDLE;
						cnt_q   <= 8'h00;
					end else if (cnt_q != 8'h01) begin
						cnt_q <= cnt_q - 8'h01;
					end else if (cycles_q != 8'hFF) begin
						cycles_q <= cycles_q + 8'h01;
					end
				end
			endcase
		end
	end

	// Operand, result and status_register
	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			operand_q <= bsf_pkg::OPERAND_RESET;
			result_q  <= bsf_pkg::OPERAND_RESET;
			flags_q   <= bsf_pkg::FLAGS_RESET;
			io_sel_q  <= 7'h00;
		end else begin
			if (wr_acc && PADDR_IN == bsf_pkg::OFS_OPERAND) begin
				operand_q <= PWDATA_IN[7:0];
			end
			if (wr_acc && PADDR_IN == bsf_pkg::OFS_IO_SEL) begin
				io_sel_q <= PWDATA_IN[6:0];
			end
			// Completion wins over a software write in the same cycle
			if (finish) begin
				flags_q <= flags_d;
			end else if (wr_acc && PADDR_IN == bsf_pkg::OFS_FLAGS) begin
				flags_q <= PWDATA_IN[7:0];
			end
			if (finish && res_we) begin
				result_q <= res_d;
			end
		end
	end

	// I/O byte space; software writes lose to a bit op finishing
	always_ff @(posedge CLOCK_IN) begin
		if (finish && cmd_q.op == bsf_pkg::OP_IO_SET) begin
			io_mem[cmd_q.io_addr][cmd_q.bit_sel] <= 1'b1;
		end else if (finish && cmd_q.op == bsf_pkg::OP_IO_CLR) begin
			io_mem[cmd_q.io_addr][cmd_q.bit_sel] <= 1'b0;
		end else if (wr_acc && PADDR_IN == bsf_pkg::OFS_IO_DATA) begin
			io_mem[io_sel_q] <= PWDATA_IN[7:0];
		end
	end

	// Control strobes, one cycle at completion
	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			BREAK_OUT        <= 1'b0;
			SLEEP_OUT        <= 1'b0;
			WDOG_RESTART_OUT <= 1'b0;
		end else begin
			BREAK_OUT        <= finish & (cmd_q.op == bsf_pkg::OP_BREAK);
			SLEEP_OUT        <= finish & (cmd_q.op == bsf_pkg::OP_SLEEP);
			WDOG_RESTART_OUT <= finish & (cmd_q.op == bsf_pkg::OP_WDOG);
		end
	end

	// Read data captured in the setup phase so it comes from a flop
	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			PRDATA_OUT <= 32'h0000_0000;
		end else if (rd_setup) begin
			unique case (PADDR_IN)
				bsf_pkg::OFS_CMD:     PRDATA_OUT <= {7'h00, cmd_q.nvm, 1'b0,
					cmd_q.io_addr, 5'h00, cmd_q.bit_sel, 3'h0, cmd_q.op};
				bsf_pkg::OFS_OPERAND: PRDATA_OUT <= {24'h000000, operand_q};
				bsf_pkg::OFS_RESULT:  PRDATA_OUT <= {24'h000000, result_q};
				bsf_pkg::OFS_FLAGS:   PRDATA_OUT <= {24'h000000, flags_q};
				bsf_pkg::OFS_STATUS:  PRDATA_OUT <= {16'h0000, cycles_q,
					6'h00, nvm_busy_q, BUSY_OUT};
				bsf_pkg::OFS_IO_SEL:  PRDATA_OUT <= {25'h0000000, io_sel_q};
				bsf_pkg::OFS_IO_DATA: PRDATA_OUT <= {24'h000000,
					io_mem[io_sel_q]};
				default:              PRDATA_OUT <= 32'h0000_0000;
			endcase
		end
	end

endmodule // bit_shift_flag_unit

// ==== verification/bsf_monitor.sv ====
/*
 Port checks for the bit, shift and flag unit: command length, strobes
 and the interrupt enable level. Bound in from the bench top; one clock.
*/
module bsf_monitor (
	// Clock and reset
	input wire logic        CLOCK_IN,
	input wire logic        RESETN_IN,
	// APB
	input wire logic        PSEL_IN,
	input wire logic        PENABLE_IN,
	input wire logic        PWRITE_IN,
	input wire logic [7:0]  PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic        PREADY_OUT,
	input wire logic        PSLVERR_OUT,
	// Core side
	input wire logic        NVM_BUSY_IN,
	input wire logic        IRQ_ENABLE_OUT,
	input wire logic        BUSY_OUT,
	input wire logic        BREAK_OUT,
	input wire logic        SLEEP_OUT,
	input wire logic        WDOG_RESTART_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       go;
	logic [4:0] op;
	logic       io_op;
	logic       quiet;
	logic       plain;
	logic       io_go;
	logic [2:0] quiet_q;
	assign go = PSEL_IN && PENABLE_IN && PWRITE_IN && !BUSY_OUT
		&& PADDR_IN == bsf_pkg::OFS_CMD;
	assign op = PWDATA_IN[4:0];
	assign io_op = op == 5'h07 || op == 5'h08;
	assign quiet = quiet_q == 3'h4;
	assign plain = go && quiet && !io_op && !PWDATA_IN[24];
	assign io_go = go && quiet && io_op && !PWDATA_IN[24];
	// Synced NVM busy lags the pin; judge exact lengths only after a calm spell
	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN)
			quiet_q <= 3'h0;
		else if (NVM_BUSY_IN)
			quiet_q <= 3'h0;
		else if (!quiet)
			quiet_q <= quiet_q + 3'h1;
	end
	default clocking cb @(posedge CLOCK_IN);
	endclocking
	default disable iff (!RESETN_IN);
	sequence busy1;
		BUSY_OUT ##1 !BUSY_OUT;
	endsequence
	sequence busy2;
		BUSY_OUT [*2] ##1 !BUSY_OUT;
	endsequence
	sequence busy3;
		BUSY_OUT [*3] ##1 !BUSY_OUT;
	endsequence
	a_plain_one: assert property (plain |=> busy1)
		else $error("single cycle command length wrong");
	a_io_two: assert property (io_go && PWDATA_IN[22] |=> busy2)
		else $error("io bit command length wrong");
	a_io_low_extra: assert property (io_go && !PWDATA_IN[22] |=> busy3)
		else $error("low io command lacks extra cycle");
	a_nvm_extra: assert property (go && !io_op && PWDATA_IN[24]
		|=> BUSY_OUT [*2]) else $error("nvm path lacks extra cycle");
	a_irq_on: assert property (plain && op == 5'h1B |-> ##2 IRQ_ENABLE_OUT)
		else $error("interrupt enable not set");
	a_irq_off: assert property (plain && op == 5'h1C |-> ##2 !IRQ_ENABLE_OUT)
		else $error("interrupt enable not cleared");
	a_break_pulse: assert property (plain && op == 5'h1D
		|-> ##2 BREAK_OUT ##1 !BREAK_OUT) else $error("break pulse wrong");
	a_sleep_pulse: assert property (plain && op == 5'h1E
		|-> ##2 SLEEP_OUT ##1 !SLEEP_OUT) else $error("sleep pulse wrong");
	a_wdog_pulse: assert property (plain && op == 5'h1F
		|-> ##2 WDOG_RESTART_OUT) else $error("watchdog pulse missing");
	a_strobe_cause: assert property ((BREAK_OUT || SLEEP_OUT
		|| WDOG_RESTART_OUT) |-> $fell(BUSY_OUT))
		else $error("strobe without finishing command");
endmodule // bsf_monitor

// ==== verification/test_bit_shift_flag_unit.sv ====
/*
 Self-checking bench for the bit, shift and flag unit over APB.
 Assumes the package and the design are compiled before it.
*/
module test_bit_shift_flag_unit;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] flags_ofs = 8'h0C;
	localparam logic [7:0] pat = 8'hA5;
	localparam logic [7:0] vals [4] = '{8'h81, 8'h00, 8'h40, 8'hFF};
	localparam int fpos [8] = '{0, 2, 1, 4, 3, 6, 5, 7};
	localparam logic [4:0] ctl [4] = '{5'h00, 5'h1D, 5'h1E, 5'h1F};
	logic clock = 1'b0, resetn = 1'b0, nvm_busy = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd, e;
	logic pready, pslverr, irq_en, busy, brk, slp, wdg, err;
	logic [2:0] strb;
	int n_fail = 0, tests_run = 0, ncyc;
	always #2.5 clock = ~clock;
	bit_shift_flag_unit DUT (.CLOCK_IN(clock), .RESETN_IN(resetn),
		.PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
		.PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .NVM_BUSY_IN(nvm_busy),
		.IRQ_ENABLE_OUT(irq_en), .BUSY_OUT(busy), .BREAK_OUT(brk),
		.SLEEP_OUT(slp), .WDOG_RESTART_OUT(wdg));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int k = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			n_fail++;
			print_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Counts busy cycles; strobes are caught at the first idle sample
	task automatic exec(input logic [4:0] op, input logic [2:0] b,
		input logic [6:0] io, input logic nvm);
		apb(1'b1, bsf_pkg::OFS_CMD,
			{7'h00, nvm, 1'b0, io, 5'h00, b, 3'h0, op});
		ncyc = 0;
		for (int i = 0; i < 60; i++) begin
			@(posedge clock);
			strb = {brk, slp, wdg};
			if (busy !== 1'b1)
				break;
			ncyc++;
		end
		if (busy === 1'b1) begin
			n_fail++;
			print_verdict();
		end
	endtask
	function automatic logic [15:0] model(input logic [4:0] op,
		input logic [7:0] a, input logic [7:0] s);
		logic [7:0] r;
		logic [7:0] f;
		logic       c;
		f = s;
		c = s[0];
		case (op)
			5'h01: {c, r} = {a, 1'b0};
			5'h02: {r, c} = {1'b0, a};
			5'h03: {c, r} = {a, s[0]};
			5'h04: {r, c} = {s[0], a};
			5'h05: {r, c} = {a[7], a};
			default: r = {a[3:0], a[7:4]};
		endcase
		if (op != 5'h06) begin
			f[0] = c;
			f[1] = r == 8'h00;
			f[2] = r[7];
			f[3] = r[7] ^ c;
			if (op == 5'h01 || op == 5'h03)
				f[5] = a[3];
		end
		return {r, f};
	endfunction
	initial begin
		logic [15:0] m;
		logic [7:0]  pre;
		logic [6:0]  io;
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		apb(1'b0, flags_ofs, 32'h0);
		check(rd, 32'h0);
		// Carry in and sign corners through every shift and swap
		for (int o = 1; o <= 6; o++)
			for (int v = 0; v < 8; v++) begin
				pre = v[0] ? 8'h71 : 8'h50;
				m = model(o[4:0], vals[v / 2], pre);
				apb(1'b1, flags_ofs, {24'h0, pre});
				apb(1'b1, bsf_pkg::OFS_OPERAND, {24'h0, vals[v / 2]});
				exec(o[4:0], 3'h0, 7'h40, 1'b0);
				check(ncyc, 1);
				apb(1'b0, bsf_pkg::OFS_RESULT, 32'h0);
				check(rd, {24'h0, m[15:8]});
				apb(1'b0, flags_ofs, 32'h0);
				check(rd, {24'h0, m[7:0]});
			end
		apb(1'b1, bsf_pkg::OFS_OPERAND, {24'h0, pat});
		for (int b = 0; b < 8; b++) begin
			apb(1'b1, flags_ofs, 32'h40);
			exec(5'h09, b[2:0], 7'h40, 1'b0);
			apb(1'b0, flags_ofs, 32'h0);
			check(rd, {25'h0, pat[b], 6'h00});
			apb(1'b1, flags_ofs, {25'h0, ~pat[b], 6'h00});
			exec(5'h0A, b[2:0], 7'h40, 1'b0);
			apb(1'b0, bsf_pkg::OFS_RESULT, 32'h0);
			check(rd, {24'h0, pat ^ (8'h01 << b)});
			apb(1'b0, flags_ofs, 32'h0);
			check(rd, {25'h0, ~pat[b], 6'h00});
			apb(1'b1, flags_ofs, 32'h00);
			exec(5'h0B, b[2:0], 7'h40, 1'b0);
			apb(1'b0, flags_ofs, 32'h0);
			check(rd, 32'h1 << b);
			apb(1'b1, flags_ofs, 32'hFF);
			exec(5'h0C, b[2:0], 7'h40, 1'b0);
			apb(1'b0, flags_ofs, 32'h0);
			check(rd, 32'hFF ^ (32'h1 << b));
		end
		// Each set or clear flag op from the opposite starting level
		for (int k = 0; k < 16; k++) begin
			e = k[0] ? 32'hFF ^ (32'h1 << fpos[k / 2]) : 32'h1 << fpos[k / 2];
			apb(1'b1, flags_ofs, k[0] ? 32'hFF : 32'h00);
			exec(5'h0D + k[4:0], 3'h0, 7'h40, 1'b0);
			check(ncyc, 1);
			apb(1'b0, flags_ofs, 32'h0);
			check(rd, e);
			check(irq_en, e[7]);
		end
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, flags_ofs, 32'h5A);
			exec(ctl[k], 3'h0, 7'h40, 1'b0);
			check(ncyc, 1);
			check(strb, 3'(4'h8 >> k));
			apb(1'b0, flags_ofs, 32'h0);
			check(rd, 32'h5A);
		end
		// Both sides of the low I/O boundary
		for (int k = 0; k < 4; k++) begin
			io = k[1] ? 7'h40 : 7'h3F;
			apb(1'b1, bsf_pkg::OFS_IO_SEL, {25'h0, io});
			apb(1'b1, bsf_pkg::OFS_IO_DATA, k[0] ? 32'hFF : 32'h00);
			exec(k[0] ? 5'h08 : 5'h07, 3'h5, io, 1'b0);
			check(ncyc, k[1] ? 2 : 3);
			apb(1'b0, bsf_pkg::OFS_IO_DATA, 32'h0);
			check(rd, k[0] ? 32'hDF : 32'h20);
		end
		// Set carry lands inside a busy low I/O op and must be dropped
		apb(1'b1, flags_ofs, 32'h00);
		apb(1'b1, bsf_pkg::OFS_IO_SEL, 32'h10);
		apb(1'b1, bsf_pkg::OFS_IO_DATA, 32'h00);
		apb(1'b1, bsf_pkg::OFS_CMD, 32'h0010_0007);
		apb(1'b1, bsf_pkg::OFS_CMD, 32'h0000_000D);
		apb(1'b0, flags_ofs, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, bsf_pkg::OFS_IO_DATA, 32'h0);
		check(rd, 32'h1);
		exec(5'h00, 3'h0, 7'h40, 1'b1);
		check(ncyc, 2);
		apb(1'b0, bsf_pkg::OFS_STATUS, 32'h0);
		check(rd, 32'h0000_0200);
		nvm_busy <= 1'b1;
		repeat (5) @(posedge clock);
		fork
			exec(5'h00, 3'h0, 7'h40, 1'b1);
			begin
				repeat (8) @(posedge clock);
				nvm_busy <= 1'b0;
			end
		join
		check(ncyc > 2, 1'b1);
		apb(1'b0, bsf_pkg::OFS_STATUS, 32'h0);
		check(rd, {16'h0000, ncyc[7:0], 8'h00});
		apb(1'b0, 8'h1C, 32'h0);
		check({err, rd[30:0]}, 32'h8000_0000);
		print_verdict();
	end
endmodule // test_bit_shift_flag_unit
bind bit_shift_flag_unit bsf_monitor u_mon (.CLOCK_IN(CLOCK_IN),
	.RESETN_IN(RESETN_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
	.PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
	.PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT), .NVM_BUSY_IN(NVM_BUSY_IN),
	.IRQ_ENABLE_OUT(IRQ_ENABLE_OUT), .BUSY_OUT(BUSY_OUT),
	.BREAK_OUT(BREAK_OUT), .SLEEP_OUT(SLEEP_OUT),
	.WDOG_RESTART_OUT(WDOG_RESTART_OUT));
